// >>> hw/ersm_pkg.sv
// Package: register map, field positions, line-side carrier and code classes
package ersm_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ERSM_AW = 12;
    localparam int ERSM_DW = 32;
    localparam int ERSM_IW = 10;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [ERSM_IW-1:0] ERSM_IDX_RRA = 10'h068;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_SA4 = 10'h069;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_SA5 = 10'h06a;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_SA6 = 10'h06b;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_SA7 = 10'h06c;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_SA8 = 10'h06d;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_LAST = 10'h06e;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_CODE = 10'h06f;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_MODE = 10'h080;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_CTL1 = 10'h081;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_MASK = 10'h090;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_STAT = 10'h091;
    localparam logic [ERSM_IW-1:0] ERSM_IDX_IRQM = 10'h092;

    // ------------------------------------------------------------
    // Field positions, widths and reset values
    // ------------------------------------------------------------
    localparam int ERSM_MM_FRAMER_ENABLE = 7;
    localparam int ERSM_MM_INIT = 6;
    localparam int ERSM_MM_SRST = 1;
    localparam int ERSM_MM_STD = 0;
    localparam int ERSM_C1_SYNC_QUALIFY_LENGTH = 7;
    localparam int ERSM_ST_SPARE = 0;
    localparam int ERSM_ST_CODE = 1;
    localparam int ERSM_ST_W = 2;
    localparam int ERSM_SPARE_N = 5;
    localparam int ERSM_CAP_W = 8;
    localparam int ERSM_CODE_W = 4;
    localparam logic [7:0] ERSM_RST8 = 8'h00;

    // ------------------------------------------------------------
    // Timing and bus answers
    // ------------------------------------------------------------
    localparam logic [4:0] ERSM_SYNC_SHORT = 5'd10;
    localparam logic [4:0] ERSM_SYNC_LONG = 5'd24;
    localparam logic [1:0] ERSM_RESP_OKAY = 2'b00;
    localparam logic [1:0] ERSM_RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // One received non-align frame: spare[4] is Sa4 ... spare[0] is Sa8
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [3:0] frame;
        logic remote_alarm;
        logic [ERSM_SPARE_N-1:0] spare;
    } ersm_nfas_t;

    // Sa6 codeword classes
    typedef enum logic [2:0] {
        ERSM_CLS_NONE,
        ERSM_CLS_8,
        ERSM_CLS_A,
        ERSM_CLS_C,
        ERSM_CLS_E,
        ERSM_CLS_F
    } ersm_code_cls_t;

endpackage

// >>> hw/ersm_frame_capture.sv
// Per-frame capture register: one bit per odd frame of the multiframe
`timescale 1ns/100ps
module ersm_frame_capture
    import ersm_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Capture strobe, slot and bit
    input wire logic capture,
    input wire logic [$clog2(W)-1:0] slot,
    input wire logic bit_in,
    // Captured bits
    output logic [W-1:0] bits_q
);

    // ------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------
    // Only the addressed slot moves; the others keep last multiframe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bits_q <= '0;
        end else if (capture) begin
            bits_q[slot] <= bit_in;
        end
    end

endmodule

// >>> hw/ersm_codeword.sv
// Sa6 codeword sampler: four received Sa6 bits, no submultiframe alignment
`timescale 1ns/100ps
module ersm_codeword
    import ersm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic rx_hold,
    // Sa6 bit stream
    input wire logic sample,
    input wire logic sa6_bit,
    // Reported codeword
    output logic [ERSM_CODE_W-1:0] code_q,
    output logic updated_q,
    output ersm_code_cls_t class_q
);

    logic [ERSM_CODE_W-1:0] shift_q; // Bits gathered so far
    logic [1:0] count_q; // Bits in the current group
    logic [ERSM_CODE_W-1:0] next_code; // Group being completed
    logic [2:0] ones; // Ones in that group
    ersm_code_cls_t cls_d; // Class of that group

    assign next_code = {shift_q[ERSM_CODE_W-2:0], sa6_bit};

    // ------------------------------------------------------------
    // Classification by weight; any rotation maps to its code
    // ------------------------------------------------------------
    always_comb begin
        ones = 3'(next_code[0]) + 3'(next_code[1]) + 3'(next_code[2]) + 3'(next_code[3]);
        case (ones)
            3'd1: cls_d = ERSM_CLS_8;
            3'd2: cls_d = (next_code[0] == next_code[2]) ? ERSM_CLS_A : ERSM_CLS_C;
            3'd3: cls_d = ERSM_CLS_E;
            3'd4: cls_d = ERSM_CLS_F;
            default: cls_d = ERSM_CLS_NONE;
        endcase
    end

    // ------------------------------------------------------------
    // Gathering; soft reset restarts the group but keeps the report
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shift_q <= '0;
            count_q <= '0;
            code_q <= '0;
            updated_q <= 1'b0;
            class_q <= ERSM_CLS_NONE;
        end else begin
            updated_q <= 1'b0;
            if (rx_hold) begin
                count_q <= '0;
            end else if (sample) begin
                shift_q <= next_code;
                count_q <= count_q + 2'd1;
                if (count_q == 2'd3) begin
                    code_q <= next_code;
                    class_q <= cls_d;
                    updated_q <= 1'b1;
                end
            end
        end
    end

endmodule

// >>> hw/ersm_rx_spare.sv
// Receive spare-bit capture and receive master mode register bank
`timescale 1ns/100ps
// Summary of operation
// - Remote alarm bits of odd frames captured
// - Sa4 to Sa8 odd-frame bits captured separately
// - Last Sa4..Sa8 bits in bits 4:0
// - Monitored Sa change sets latched status bit
// - Four-bit Sa6 codeword reported, unaligned
// - Codes 8, A, F by rotation
// - Codes E and C by rotation
// - Framer enable low holds framer disabled
// - Init done checks framer enable, then runs
// - Soft reset holds receiver, keeps registers
// - Bit zero selects T1 or E1 receiver
// - T1 sync qualification 10 or 24 bits
module ersm_rx_spare
    import ersm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // AXI4-Lite write address
    input wire logic [ERSM_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [ERSM_DW-1:0] s_axi_wdata,
    input wire logic [ERSM_DW/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ERSM_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [ERSM_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Receive line: one non-align frame per valid
    input wire ersm_nfas_t rx_nfas,
    // Receiver control and status
    output logic framer_active,
    output logic receiver_held,
    output logic line_standard_select,
    output logic [4:0] sync_qualify_length,
    output ersm_code_cls_t sa6_code_class,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // Receiver states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ERSM_RX_WAIT_INIT,
        ERSM_RX_DISABLED,
        ERSM_RX_RESET,
        ERSM_RX_RUN
    } ersm_rx_state_t;

    ersm_rx_state_t state_q; // Receiver state
    ersm_rx_state_t state_d; // Its next value

    // Software registers
    logic [7:0] rx_master_mode_q; // Master mode controls
    logic [7:0] rx_control_one_q; // Receive control one
    logic [ERSM_SPARE_N-1:0] spare_change_monitor_mask_q; // Sa positions watched
    logic [ERSM_ST_W-1:0] latched_status_seven_q; // Sticky events
    logic [ERSM_ST_W-1:0] irq_mask_q; // Events allowed onto irq
    logic [ERSM_SPARE_N-1:0] rx_last_spare_bits_q; // Last received Sa bits

    // Capture outputs: index 0 remote alarm, 1..5 Sa4..Sa8
    logic [ERSM_CAP_W-1:0] cap_bits [0:ERSM_SPARE_N];
    logic [ERSM_SPARE_N:0] cap_in; // Bit for each capture register
    logic [ERSM_CODE_W-1:0] code_bits; // Sa6 codeword
    logic code_updated; // Codeword completed this cycle

    // Line-side qualifiers
    logic capture_en; // Frame is taken
    logic spare_change; // Watched Sa bit changed
    logic rx_hold; // Receiver held in soft reset

    // Bus slave registers
    logic aw_held_q; // Write address captured
    logic w_held_q; // Write data captured
    logic [ERSM_AW-1:0] awaddr_q; // Held write address
    logic [ERSM_DW-1:0] wdata_q; // Held write data
    logic [ERSM_DW/8-1:0] wstrb_q; // Held byte enables
    logic bvalid_q; // Write answer pending
    logic [1:0] bresp_q; // Write answer code
    logic rvalid_q; // Read answer pending
    logic [1:0] rresp_q; // Read answer code
    logic [ERSM_DW-1:0] rdata_q; // Read answer data

    // Decode
    logic do_write; // Both halves of a write present
    logic [ERSM_IW-1:0] wr_idx; // Write register index
    logic wr_lane0; // Low byte lane enabled
    logic wr_hit; // Write address is mapped
    logic [ERSM_DW-1:0] rd_word; // Read mux output
    logic rd_hit; // Read address is mapped
    logic [ERSM_ST_W-1:0] status_set; // Events this cycle
    logic [ERSM_ST_W-1:0] status_clr; // Write-one-to-clear

    // ------------------------------------------------------------
    // Receiver mode
    // ------------------------------------------------------------
    // Mode bits other than the standard bit (bit zero, read directly) only take effect through the state machine, so a host
    // that writes them after init done sees them on the next check
    always_comb begin
        state_d = state_q;
        case (state_q)
            ERSM_RX_WAIT_INIT: begin
                if (rx_master_mode_q[ERSM_MM_INIT]) begin
                    // Decide from framer enable once init done is seen
                    state_d = rx_master_mode_q[ERSM_MM_FRAMER_ENABLE] ? ERSM_RX_RUN : ERSM_RX_DISABLED;
                end
            end
            ERSM_RX_DISABLED: begin
                if (rx_master_mode_q[ERSM_MM_FRAMER_ENABLE]) begin
                    state_d = ERSM_RX_RUN;
                end
            end
            ERSM_RX_RUN: begin
                if (!rx_master_mode_q[ERSM_MM_FRAMER_ENABLE]) begin
                    state_d = ERSM_RX_DISABLED;
                end
            end
            ERSM_RX_RESET: begin
                // Re-check init done and enable after the pulse
                state_d = ERSM_RX_WAIT_INIT;
            end
            default: begin
                state_d = ERSM_RX_WAIT_INIT;
            end
        endcase
        // Soft reset and withdrawn init done override every state
        if (rx_master_mode_q[ERSM_MM_SRST]) begin
            state_d = ERSM_RX_RESET;
        end else if (!rx_master_mode_q[ERSM_MM_INIT]) begin
            state_d = ERSM_RX_WAIT_INIT;
        end
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ERSM_RX_WAIT_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    assign rx_hold = (state_q == ERSM_RX_RESET);
    assign framer_active = (state_q == ERSM_RX_RUN);
    assign receiver_held = rx_hold;
    assign line_standard_select = rx_master_mode_q[ERSM_MM_STD];

    // Qualification length applies to T1 operation only
    always_comb begin
        if (rx_control_one_q[ERSM_C1_SYNC_QUALIFY_LENGTH]) begin
            sync_qualify_length = ERSM_SYNC_LONG;
        end else begin
            sync_qualify_length = ERSM_SYNC_SHORT;
        end
    end

    // ------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------
    // Spare bits exist in E1 only; odd frames carry the non-align word
    assign capture_en = framer_active && line_standard_select && rx_nfas.valid && rx_nfas.frame[0];
    // Top bit is the remote alarm so capture 0 is the alarm, 1..5 are Sa4..Sa8
    assign cap_in = {rx_nfas.remote_alarm, rx_nfas.spare};

    // One capture register per bit position, frame 1 lands in bit 0
    genvar gi;
    for (gi = 0; gi <= ERSM_SPARE_N; gi++) begin : g_cap
        ersm_frame_capture #(
            .W(ERSM_CAP_W)
        ) u_cap (
            .clk(clk),
            .reset(reset),
            .capture(capture_en),
            .slot(rx_nfas.frame[3:1]),
            .bit_in(cap_in[ERSM_SPARE_N - gi]),
            .bits_q(cap_bits[gi])
        );
    end

    // Sa6 codeword gathering
    ersm_codeword u_code (
        .clk(clk),
        .reset(reset),
        .rx_hold(rx_hold),
        .sample(capture_en),
        .sa6_bit(rx_nfas.spare[2]),
        .code_q(code_bits),
        .updated_q(code_updated),
        .class_q(sa6_code_class)
    );

    // ------------------------------------------------------------
    // Last received bits and change detection
    // ------------------------------------------------------------
    assign spare_change = capture_en
        && (|((rx_nfas.spare ^ rx_last_spare_bits_q) & spare_change_monitor_mask_q));

    // Held through soft reset: only reset clears it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_last_spare_bits_q <= '0;
        end else if (capture_en) begin
            rx_last_spare_bits_q <= rx_nfas.spare;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    always_comb begin
        status_set = '0;
        status_set[ERSM_ST_SPARE] = spare_change;
        status_set[ERSM_ST_CODE] = code_updated;
        status_clr = '0;
        if (do_write && wr_lane0 && wr_idx == ERSM_IDX_STAT) begin
            status_clr = wdata_q[ERSM_ST_W-1:0];
        end
    end

    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latched_status_seven_q <= '0;
        end else begin
            latched_status_seven_q <= (latched_status_seven_q & ~status_clr) | status_set;
        end
    end

    assign irq = |(latched_status_seven_q & irq_mask_q);

    // ------------------------------------------------------------
    // Write channels
    // ------------------------------------------------------------
    // Address and data are taken in either order; no new one is taken
    // until the answer has gone, so one write is under way at a time
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign do_write = aw_held_q && w_held_q;
    assign wr_idx = awaddr_q[ERSM_AW-1:2];
    assign wr_lane0 = wstrb_q[0];

    // Mapped writable and read-only registers answer OKAY
    always_comb begin
        case (wr_idx)
            ERSM_IDX_RRA, ERSM_IDX_SA4, ERSM_IDX_SA5, ERSM_IDX_SA6,
            ERSM_IDX_SA7, ERSM_IDX_SA8, ERSM_IDX_LAST, ERSM_IDX_CODE,
            ERSM_IDX_MODE, ERSM_IDX_CTL1, ERSM_IDX_MASK, ERSM_IDX_STAT,
            ERSM_IDX_IRQM: wr_hit = (awaddr_q[1:0] == 2'b00);
            default: wr_hit = 1'b0;
        endcase
    end

    // Capture of address, data and the answer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= ERSM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? ERSM_RESP_OKAY : ERSM_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------
    // Capture registers take no writes; the host is trusted to finish
    // configuration before it raises init done
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_master_mode_q <= ERSM_RST8;
            rx_control_one_q <= ERSM_RST8;
            spare_change_monitor_mask_q <= '0;
            irq_mask_q <= '0;
        end else if (do_write && wr_lane0) begin
            case (wr_idx)
                ERSM_IDX_MODE: rx_master_mode_q <= wdata_q[7:0];
                ERSM_IDX_CTL1: rx_control_one_q <= wdata_q[7:0];
                ERSM_IDX_MASK: spare_change_monitor_mask_q <= wdata_q[ERSM_SPARE_N-1:0];
                ERSM_IDX_IRQM: irq_mask_q <= wdata_q[ERSM_ST_W-1:0];
                default: begin
                    // Read-only or status: nothing stored here
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !rvalid_q;

    // Read mux; narrow registers sit in the low bits, the rest read zero
    always_comb begin
        rd_word = '0;
        rd_hit = (s_axi_araddr[1:0] == 2'b00);
        case (s_axi_araddr[ERSM_AW-1:2])
            ERSM_IDX_RRA: rd_word[ERSM_CAP_W-1:0] = cap_bits[0];
            ERSM_IDX_SA4: rd_word[ERSM_CAP_W-1:0] = cap_bits[1];
            ERSM_IDX_SA5: rd_word[ERSM_CAP_W-1:0] = cap_bits[2];
            ERSM_IDX_SA6: rd_word[ERSM_CAP_W-1:0] = cap_bits[3];
            ERSM_IDX_SA7: rd_word[ERSM_CAP_W-1:0] = cap_bits[4];
            ERSM_IDX_SA8: rd_word[ERSM_CAP_W-1:0] = cap_bits[5];
            ERSM_IDX_LAST: rd_word[ERSM_SPARE_N-1:0] = rx_last_spare_bits_q;
            ERSM_IDX_CODE: rd_word[ERSM_CODE_W-1:0] = code_bits;
            ERSM_IDX_MODE: rd_word[7:0] = rx_master_mode_q;
            ERSM_IDX_CTL1: rd_word[7:0] = rx_control_one_q;
            ERSM_IDX_MASK: rd_word[ERSM_SPARE_N-1:0] = spare_change_monitor_mask_q;
            ERSM_IDX_STAT: rd_word[ERSM_ST_W-1:0] = latched_status_seven_q;
            ERSM_IDX_IRQM: rd_word[ERSM_ST_W-1:0] = irq_mask_q;
            default: rd_hit = 1'b0;
        endcase
        if (!rd_hit) begin
            rd_word = '0;
        end
    end

    // Read answer: data registered one cycle after the address is taken
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rvalid_q <= 1'b0;
            rresp_q <= ERSM_RESP_OKAY;
            rdata_q <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? ERSM_RESP_OKAY : ERSM_RESP_SLVERR;
            rdata_q <= rd_word;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

endmodule

// >>> sim/ersm_line_model.sv
// Far-end line model: sends one non-align frame per request
`timescale 1ns/100ps
module ersm_line_model
    import ersm_pkg::*;
(
    // Clock and request
    input wire logic clk,
    input wire logic send,
    input wire logic [3:0] frm,
    input wire logic [5:0] bits,
    // Receive line
    output ersm_nfas_t nfas
);
    initial nfas = '0;
    // Frame lasts one cycle; between frames the fields flip so stale bits never look held
    always @(posedge clk) begin
        if (send) begin
            nfas <= {1'b1, frm, bits};
        end else begin
            nfas <= {1'b0, ~nfas[9:0]};
        end
    end
endmodule

// >>> sim/ersm_rx_spare_props.sv
// Checker: bus handshake and receiver output relations
`timescale 1ns/100ps
module ersm_rx_spare_props
    import ersm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bus signals
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // Receiver outputs
    input wire logic framer_active,
    input wire logic receiver_held,
    input wire logic [4:0] sync_qualify_length
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready with bvalid");
    ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready with rvalid");
    b_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    r_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'hffc
        |=> s_axi_rresp == ERSM_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
    r_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits");
    held_idle_a: assert property (receiver_held |-> !framer_active) else $error("held yet running");
    sync_len_a: assert property (sync_qualify_length == 5'd10 || sync_qualify_length == 5'd24)
        else $error("bad sync length");
endmodule
bind ersm_rx_spare ersm_rx_spare_props u_props (.*);

// >>> sim/e1_rx_spare_bits_and_rx_mode_tb_top.sv
// Testbench: register bank over AXI4-Lite against an integer model
`timescale 1ns/100ps
module e1_rx_spare_bits_and_rx_mode_tb_top import ersm_pkg::*;;
    logic clk = 0, reset = 1, send = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hf, frm = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic framer_active, receiver_held, line_standard_select;
    logic [4:0] sync_qualify_length;
    logic [5:0] bits = 0;
    ersm_nfas_t rx_nfas;
    ersm_code_cls_t sa6_code_class;
    int n_fail = 0, checks_done = 0, cyc = 0, seed = 32'hd7bf;
    int cap[6], last = 0, stat = 0, hist = 0, cnt = 0, code = 0, on = 0;
    int pat[8] = '{8, 10, 12, 14, 15, 1, 5, 9};
    int cls[8] = '{1, 2, 3, 4, 5, 1, 2, 3};
    always #2.5 clk = ~clk;
    ersm_rx_spare u_dut (.*);
    ersm_line_model u_line (.clk(clk), .send(send), .frm(frm), .bits(bits), .nfas(rx_nfas));
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        chk(s_axi_bresp, 0);
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk(rv, e);
    endtask
    // One frame on the line; the model keeps captures, change status and codeword
    task automatic frame(input logic [3:0] f, input logic [5:0] b);
        @(posedge clk);
        send <= 1;
        frm <= f;
        bits <= b;
        @(posedge clk);
        send <= 0;
        if (f[0] && on) begin
            for (int i = 0; i < 6; i++) cap[i][f[3:1]] = b[5-i];
            if ((b[4:0] ^ last) & 31) stat |= 1;
            last = b[4:0];
            hist = ((hist << 1) | b[2]) & 15;
            cnt++;
            if (cnt % 4 == 0) begin
                code = hist;
                stat |= 2;
            end
        end
        repeat (3) @(posedge clk);
    endtask
    initial begin
        foreach (cap[i]) cap[i] = 0;
        repeat (16) @(posedge clk);
        reset <= 0;
        for (int k = 0; k < 10; k++) rc(k < 8 ? 12'h1a0 + 4 * k : 12'h1e0 + 4 * k, 0);
        rd(12'hffc);
        chk(rr, 2);
        $display("scenario 1 done");
        wr(12'h200, 32'h81);
        chk(framer_active, 0);
        wr(12'h200, 32'hc1);
        wr(12'h240, 32'h1f);
        wr(12'h248, 32'h1);
        on = 1;
        chk(framer_active, 1);
        chk(line_standard_select, 1);
        for (int k = 0; k < 16; k++) frame(2 * (k % 8) + 1, $random(seed));
        frame(2, $random(seed));
        for (int i = 0; i < 6; i++) rc(12'h1a0 + 4 * i, cap[i]);
        rc(12'h1b8, last);
        for (int p = 0; p < 8; p++) begin
            for (int j = 0; j < 4; j++) frame(2 * j + 1, {3'b000, pat[p][3-j], 2'b00});
            rc(12'h1bc, code);
            chk(sa6_code_class, cls[p]);
        end
        $display("scenario 2 done");
        rc(12'h244, stat);
        chk(irq, stat & 1);
        wr(12'h244, 32'h3);
        stat = 0;
        chk(irq, 0);
        frame(1, 6'h3f ^ last);
        chk(irq, 1);
        wr(12'h248, 32'h0);
        chk(irq, 0);
        wr(12'h200, 32'hc3);
        on = 0;
        @(posedge clk);
        chk(receiver_held, 1);
        frame(1, 6'h3f ^ last);
        wr(12'h200, 32'h41);
        chk(framer_active, 0);
        frame(1, 6'h3f ^ last);
        rc(12'h200, 32'h41);
        rc(12'h1a4, cap[1]);
        wr(12'h200, 32'hc0);
        frame(1, 6'h3f ^ last);
        chk(line_standard_select, 0);
        rc(12'h1a4, cap[1]);
        wr(12'h204, 32'h80);
        chk(sync_qualify_length, 24);
        wr(12'h204, 32'h0);
        chk(sync_qualify_length, 10);
        wr(12'h1a0, 32'hff);
        rc(12'h1a0, cap[0]);
        $display("scenario 3 done");
        end_sim();
    end
endmodule
